/* File: verilog/nfaer_pkg.sv */
package nfaer_pkg;
    localparam logic [9:0] IDX_LOG_BASE = 10'h064;
    localparam logic [9:0] IDX_LOG_LAST = 10'h0C7;
    localparam logic [9:0] IDX_BITMAP_BASE = 10'h168;
    localparam logic [9:0] IDX_BITMAP_LAST = 10'h187;
    localparam logic [9:0] IDX_CODE = 10'h190;
    localparam logic [9:0] IDX_STATUS = 10'h192;
    localparam logic [9:0] IDX_DUMMY = 10'h211;
    localparam logic [9:0] IDX_LOG_STATE = 10'h220;
    localparam logic [9:0] IDX_CONFIG = 10'h221;
    localparam int LOG_WORDS = 100;
    localparam logic [4:0] LOG_ENTRIES = 5'h14;
    localparam logic [6:0] LOG_ENTRY_WORDS = 7'h05;
    localparam logic [15:0] ALARM_MAX = 16'h01FF;
    localparam logic [15:0] SRC_CLEAR_ALL = 16'hFFFF;
    localparam logic [15:0] USER_CODE_BASE = 16'h4101;
    localparam int STATUS_ALARM_BIT = 15;
    localparam int CFG_NOLOG_BIT = 0;
    localparam logic [15:0] RESET_WORD = 16'h0000;
    localparam logic [15:0] SYS_CODE_SETUP = 16'h009B;
    localparam logic [15:0] SYS_CODE_ANALOG = 16'h008A;
    localparam logic [15:0] SYS_CODE_OPTION = 16'h00D1;
    localparam logic [15:0] SYS_CODE_BATTERY = 16'h00F7;
    localparam logic [15:0] SYS_DETAIL_OPTION = 16'h0001;
    localparam logic [1:0] SEV_NONE = 2'h0;
    localparam logic [1:0] SEV_USER = 2'h1;
    localparam logic [1:0] SEV_SYSTEM = 2'h2;
    localparam logic [1:0] SEV_FATAL = 2'h3;
endpackage

/* File: verilog/nfaer_lowest.sv */
`timescale 1ns/1ps
// Finds the lowest set bit of the alarm bitmap; bit 0 is never an alarm.
module nfaer_lowest (
    input wire logic [511:0] vec, // Executed-number bitmap.
    output logic [8:0] idx, // Lowest set alarm number.
    output logic found // Any bit from 1 to 511 set.
);
    always_comb begin
        idx = 9'h000;
        found = 1'b0;
        for (int i = 511; i >= 1; i--) begin
            if (vec[i]) begin
                idx = 9'(i);
                found = 1'b1;
            end
        end
    end
endmodule

/* File: verilog/nfaer_core.sv */
`timescale 1ns/1ps
module nfaer_core
    import nfaer_pkg::*;
(
    input wire logic ref_clk, // 10 MHz system clock.
    input wire logic rst, // Synchronous reset, active high.
    input wire logic [11:0] avs_address, // Byte address.
    input wire logic avs_read, // Read request.
    input wire logic avs_write, // Write request.
    input wire logic [31:0] avs_writedata, // Write data.
    input wire logic [3:0] avs_byteenable, // Byte lanes.
    output logic [31:0] avs_readdata, // Read data.
    output logic avs_waitrequest, // Stall.
    input wire logic instr_req, // One-cycle instruction strobe.
    input wire logic [15:0] alarm_num, // Alarm number operand.
    input wire logic src_is_word, // Source is a word reference.
    input wire logic [15:0] src_word0, // Constant or first source word.
    input wire logic [15:0] src_word1, // Second source word.
    input wire logic [127:0] msg_words, // Eight words from the source on.
    input wire logic [63:0] cal_time, // Calendar time, four words.
    input wire logic ext_err_valid, // Other error raised this cycle.
    input wire logic [15:0] ext_err_code, // Its code.
    input wire logic ext_err_fatal, // It is fatal.
    output logic instr_done, // Pulse after each instruction.
    output logic instr_error_flag, // Instruction error flag.
    output logic halt_req, // Stop request.
    output logic [127:0] msg_text, // Captured message.
    output logic msg_valid, // Message held.
    output logic [8:0] msg_alarm_num // Alarm owning the message.
);
    // Returns {valid, slot} for an injected code and details pair.
    function automatic logic [2:0] sys_lookup(input logic [15:0] c, input logic [15:0] d);
        logic [2:0] r;
        r = 3'b000;
        if (c == SYS_CODE_SETUP) begin
            r = 3'b100;
        end else if (c == SYS_CODE_ANALOG) begin
            r = 3'b101;
        end else if (c == SYS_CODE_OPTION && d == SYS_DETAIL_OPTION) begin
            r = 3'b110;
        end else if (c == SYS_CODE_BATTERY) begin
            r = 3'b111;
        end
        return r;
    endfunction

    function automatic logic [15:0] sys_code(input logic [1:0] s);
        logic [15:0] c;
        case (s)
            2'd0: c = SYS_CODE_SETUP;
            2'd1: c = SYS_CODE_ANALOG;
            2'd2: c = SYS_CODE_OPTION;
            default: c = SYS_CODE_BATTERY;
        endcase
        return c;
    endfunction

    function automatic logic [15:0] user_code(input logic [8:0] n);
        return 16'(USER_CODE_BASE + {7'h00, n} - 16'h0001);
    endfunction

    logic [511:0] bitmap_reg;
    logic [511:0] bitmap_next;
    logic [3:0] sys_active_reg;
    logic [3:0] sys_active_next;
    logic [15:0] code_reg;
    logic [15:0] code_next;
    logic fatal_reg;
    logic recalc_reg;
    logic [15:0] dummy_reg;
    logic [15:0] config_reg;
    logic [4:0] head_reg;
    logic [4:0] count_reg;
    logic [15:0] log_mem [0:LOG_WORDS-1];
    logic er_reg;
    logic done_reg;
    logic [127:0] msg_reg;
    logic msg_valid_reg;
    logic [8:0] msg_num_reg;
    logic ack_reg;
    logic [31:0] rdata_reg;

    // Instruction decode.
    wire num_bad = alarm_num > ALARM_MAX;
    wire dummy_ok = dummy_reg != RESET_WORD && dummy_reg <= ALARM_MAX;
    wire num_valid = instr_req && !num_bad;
    wire is_clear = num_valid && alarm_num == RESET_WORD;
    wire is_sys = num_valid && dummy_ok && alarm_num == dummy_reg;
    wire is_user = num_valid && alarm_num != RESET_WORD && !is_sys;
    wire [8:0] user_num = alarm_num[8:0];
    wire [2:0] sys_hit = sys_lookup(src_word0, src_word1);
    wire sys_raise = is_sys && sys_hit[2];
    wire sys_bad = is_sys && !sys_hit[2];
    wire src_num_ok = src_word0 != RESET_WORD && src_word0 <= ALARM_MAX;
    wire clr_all = is_clear && !src_is_word && src_word0 == SRC_CLEAR_ALL;
    wire clr_num = is_clear && !src_is_word && src_num_ok;
    wire clr_top = is_clear && !clr_all && !clr_num;

    // Most serious standing errors: system slots first, then lowest user alarm.
    wire [8:0] low_idx;
    wire low_found;
    nfaer_lowest u_lowest (
        .vec(bitmap_reg),
        .idx(low_idx),
        .found(low_found)
    );
    wire sys_any = |sys_active_reg;
    wire [1:0] sys_first = sys_active_reg[0] ? 2'd0 :
                           sys_active_reg[1] ? 2'd1 :
                           sys_active_reg[2] ? 2'd2 : 2'd3;
    wire [15:0] rem_code = sys_any ? sys_code(sys_first) :
                           low_found ? user_code(low_idx) : RESET_WORD;

    always_comb begin
        bitmap_next = bitmap_reg;
        sys_active_next = sys_active_reg;
        if (clr_all) begin
            bitmap_next = '0;
            sys_active_next = 4'h0;
        end
        if (clr_num) begin
            bitmap_next[src_word0[8:0]] = 1'b0;
        end
        if (clr_top && sys_any) begin
            sys_active_next[sys_first] = 1'b0;
        end else if (clr_top && low_found) begin
            bitmap_next[low_idx] = 1'b0;
        end
        if (is_user) begin
            bitmap_next[user_num] = 1'b1;
        end
        if (sys_raise) begin
            sys_active_next[sys_hit[1:0]] = 1'b1;
        end
    end

    // Severity ranking of what arrives in this cycle.
    wire [1:0] ext_sev = !ext_err_valid ? SEV_NONE : ext_err_fatal ? SEV_FATAL : SEV_SYSTEM;
    wire [1:0] ins_sev = sys_raise ? SEV_SYSTEM : is_user ? SEV_USER : SEV_NONE;
    wire [15:0] ins_code = sys_raise ? src_word0 : user_code(user_num);
    wire ext_wins = ext_err_valid && ext_sev >= ins_sev;
    wire [15:0] win_code = ext_wins ? ext_err_code : ins_code;
    wire win_fatal = ext_wins && ext_err_fatal;
    wire any_new = ext_err_valid || sys_raise || is_user;

    // A held fatal code is never displaced by a non-fatal one.
    always_comb begin
        code_next = code_reg;
        if (any_new) begin
            if (win_fatal || !fatal_reg) begin
                code_next = win_code;
            end
        end else if (recalc_reg && !fatal_reg) begin
            code_next = rem_code;
        end
    end

    // Only one log entry per cycle; the most serious event of the cycle is kept.
    wire user_logs = is_user && !config_reg[CFG_NOLOG_BIT];
    wire log_en = ext_err_valid || sys_raise || user_logs;
    wire [15:0] log_code = ext_err_valid ? ext_err_code : ins_code;
    wire [6:0] log_base = 7'(head_reg * LOG_ENTRY_WORDS);
    wire head_wrap = head_reg == LOG_ENTRIES - 5'h01;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bitmap_reg <= '0;
            sys_active_reg <= 4'h0;
            code_reg <= RESET_WORD;
            fatal_reg <= 1'b0;
            recalc_reg <= 1'b0;
        end else begin
            bitmap_reg <= bitmap_next;
            sys_active_reg <= sys_active_next;
            code_reg <= code_next;
            fatal_reg <= fatal_reg || (ext_err_valid && ext_err_fatal);
            recalc_reg <= is_clear;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            head_reg <= 5'h00;
            count_reg <= 5'h00;
        end else if (log_en) begin
            head_reg <= head_wrap ? 5'h00 : 5'(head_reg + 5'h01);
            if (count_reg != LOG_ENTRIES) begin
                count_reg <= 5'(count_reg + 5'h01);
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (log_en) begin
            log_mem[log_base] <= log_code;
            for (int w = 0; w < 4; w++) begin
                log_mem[7'(log_base + 7'(w + 1))] <= cal_time[16*w +: 16];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            er_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            done_reg <= instr_req;
            if (instr_req) begin
                er_reg <= num_bad || sys_bad;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            msg_reg <= '0;
            msg_valid_reg <= 1'b0;
            msg_num_reg <= 9'h000;
        end else if (is_user && src_is_word) begin
            msg_reg <= msg_words;
            msg_valid_reg <= 1'b1;
            msg_num_reg <= user_num;
        end else if (is_user || clr_all) begin
            msg_valid_reg <= 1'b0;
        end
    end

    assign instr_done = done_reg;
    assign instr_error_flag = er_reg;
    assign halt_req = 1'b0;
    assign msg_text = msg_reg;
    assign msg_valid = msg_valid_reg;
    assign msg_alarm_num = msg_num_reg;

    // Register bus: one wait state on every access, answer at the second edge.
    wire access = avs_read || avs_write;
    wire [9:0] reg_idx = avs_address[11:2];
    wire in_log = reg_idx >= IDX_LOG_BASE && reg_idx <= IDX_LOG_LAST;
    wire in_bitmap = reg_idx >= IDX_BITMAP_BASE && reg_idx <= IDX_BITMAP_LAST;
    wire [6:0] log_idx = 7'(reg_idx - IDX_LOG_BASE);
    wire [4:0] bm_idx = 5'(reg_idx - IDX_BITMAP_BASE);
    wire [15:0] status_word = {|bitmap_reg, 15'h0000};
    wire wr_take = avs_write && ack_reg;
    wire [15:0] wmask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

    logic [15:0] rd_word;
    always_comb begin
        rd_word = RESET_WORD;
        if (in_log) begin
            rd_word = log_mem[log_idx];
        end else if (in_bitmap) begin
            rd_word = bitmap_reg[{bm_idx, 4'h0} +: 16];
        end else begin
            case (reg_idx)
                IDX_CODE: rd_word = code_reg;
                IDX_STATUS: rd_word = status_word;
                IDX_DUMMY: rd_word = dummy_reg;
                IDX_LOG_STATE: rd_word = {3'h0, head_reg, 3'h0, count_reg};
                IDX_CONFIG: rd_word = config_reg;
                default: rd_word = RESET_WORD;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ack_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ack_reg <= access && !ack_reg;
            if (avs_read && !ack_reg) begin
                rdata_reg <= {16'h0000, rd_word};
            end
        end
    end

    // The issuer keeps the dummy number within 1 to 511; other values disable injection.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            dummy_reg <= RESET_WORD;
            config_reg <= RESET_WORD;
        end else if (wr_take) begin
            if (reg_idx == IDX_DUMMY) begin
                dummy_reg <= (dummy_reg & ~wmask) | (avs_writedata[15:0] & wmask);
            end
            if (reg_idx == IDX_CONFIG) begin
                config_reg <= (config_reg & ~wmask) | (avs_writedata[15:0] & wmask);
            end
        end
    end

    assign avs_waitrequest = access && !ack_reg;
    assign avs_readdata = rdata_reg;
endmodule

/* File: verif/nfaer_core_checker.sv */
`timescale 1ns/1ps
module nfaer_core_checker (
    input wire logic ref_clk, // Clock.
    input wire logic rst, // Reset.
    input wire logic instr_req, // Strobe.
    input wire logic [15:0] alarm_num, // Alarm number.
    input wire logic src_is_word, // Word source.
    input wire logic [15:0] src_word0, // First word.
    input wire logic [127:0] msg_words, // Message words.
    input wire logic instr_done, // Done pulse.
    input wire logic instr_error_flag, // Error flag.
    input wire logic halt_req, // Stop request.
    input wire logic [127:0] msg_text, // Message.
    input wire logic msg_valid, // Message held.
    input wire logic [8:0] msg_alarm_num // Message owner.
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    wire user_num = alarm_num != 16'h0000 && alarm_num <= 16'h01FF;
    property p_range_flag;
        instr_req && alarm_num > 16'h01FF |=> instr_done && instr_error_flag;
    endproperty
    a_range_flag: assert property (p_range_flag) else $error("range flag");
    property p_clear_ok;
        instr_req && alarm_num == 16'h0000 |=> instr_done && !instr_error_flag;
    endproperty
    a_clear_ok: assert property (p_clear_ok) else $error("clear flagged");
    property p_flag_holds;
        !instr_req [*2] |-> $stable(instr_error_flag);
    endproperty
    a_flag_holds: assert property (p_flag_holds) else $error("flag moved");
    property p_no_halt;
        instr_req |-> !halt_req ##1 !halt_req ##1 !halt_req;
    endproperty
    a_no_halt: assert property (p_no_halt) else $error("halt raised");
    property p_msg_capture;
        instr_req && src_is_word && user_num |=> msg_valid
            && msg_alarm_num == $past(alarm_num[8:0]) && msg_text == $past(msg_words);
    endproperty
    a_msg_capture: assert property (p_msg_capture) else $error("message lost");
    property p_const_no_msg;
        instr_req && !src_is_word && user_num |=> $stable(msg_text);
    endproperty
    a_const_no_msg: assert property (p_const_no_msg) else $error("message taken");
    property p_clear_all;
        instr_req && alarm_num == 16'h0000 && !src_is_word && src_word0 == 16'hFFFF
            |=> !msg_valid;
    endproperty
    a_clear_all: assert property (p_clear_all) else $error("message kept");
    property p_clear_one;
        instr_req && alarm_num == 16'h0000 && src_word0 != 16'hFFFF |=> $stable(msg_text);
    endproperty
    a_clear_one: assert property (p_clear_one) else $error("message changed");
    c_clear: cover property (instr_req && alarm_num == 16'h0000);
    c_flag: cover property (instr_error_flag);
    c_msg: cover property (msg_valid);
endmodule

/* File: verif/nfaer_seq.sv */
`timescale 1ns/1ps
module nfaer_seq (
    input wire logic ref_clk, // Clock.
    output logic instr_req, // Strobe.
    output logic [15:0] alarm_num, // Alarm number.
    output logic src_is_word, // Word source.
    output logic [15:0] src_word0, // First word.
    output logic [15:0] src_word1, // Second word.
    output logic [127:0] msg_words, // Message words.
    output logic [63:0] cal_time, // Time words.
    output logic ext_err_valid, // Other error.
    output logic [15:0] ext_err_code, // Its code.
    output logic ext_err_fatal // Fatal.
);
    int seed = 39284;
    logic [127:0] sent_msg;
    logic [63:0] sent_time;
    initial begin
        {instr_req, alarm_num, src_is_word, src_word0, src_word1} = '0;
        {msg_words, cal_time, ext_err_valid, ext_err_code, ext_err_fatal} = '0;
    end
    // Released operands are inverted so the core cannot lean on stale values.
    task automatic issue(input logic [15:0] num, input logic word, input logic [15:0] w0,
                         input logic [15:0] w1, input logic ext);
        sent_msg = {$random(seed), $random(seed), $random(seed), $random(seed)};
        sent_time = {$random(seed), $random(seed)};
        instr_req <= 1'b1;
        alarm_num <= num;
        src_is_word <= word;
        src_word0 <= w0;
        src_word1 <= w1;
        msg_words <= sent_msg;
        cal_time <= sent_time;
        ext_err_valid <= ext;
        ext_err_code <= 16'h80F1;
        ext_err_fatal <= ext;
        @(posedge ref_clk);
        instr_req <= 1'b0;
        alarm_num <= ~num;
        src_is_word <= ~word;
        src_word0 <= ~w0;
        src_word1 <= ~w1;
        msg_words <= ~sent_msg;
        cal_time <= ~sent_time;
        ext_err_valid <= 1'b0;
    endtask
endmodule

/* File: verif/testbench.sv */
`timescale 1ns/1ps
module testbench;
    import nfaer_pkg::*;
    logic ref_clk, rst, avs_read, avs_write, avs_waitrequest, instr_req, src_is_word;
    logic ext_err_valid, ext_err_fatal, instr_done, instr_error_flag, halt_req, msg_valid;
    logic [11:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0] avs_byteenable;
    logic [15:0] alarm_num, src_word0, src_word1, ext_err_code, n;
    logic [127:0] msg_words, msg_text;
    logic [63:0] cal_time;
    logic [8:0] msg_alarm_num;
    logic [31:0] rd_q[$];
    logic flag_q[$];
    logic [15:0] codes[4] = '{SYS_CODE_SETUP, SYS_CODE_ANALOG, SYS_CODE_OPTION, SYS_CODE_BATTERY};
    logic [15:0] dets[4] = '{16'h5A3C, 16'h0000, SYS_DETAIL_OPTION, 16'h0000};
    int bad_count = 0, checked = 0, cycles = 0, seed = 39284;
    nfaer_core nfaer_core_inst (.*);
    nfaer_seq nfaer_seq_inst (.*);
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    task automatic chk(input string nm, input logic [127:0] got, input logic [127:0] exp);
        checked++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
            bad_count++;
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic bus(input logic [9:0] idx, input logic wr, input logic [15:0] d);
        avs_address <= {idx, 2'b00};
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= {16'h0000, d};
        if (!wr) rd_q.push_back({16'h0000, d});
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic ins(input logic [15:0] num, input logic word, input logic [15:0] w0,
                       input logic [15:0] w1, input logic ext, input logic flag);
        flag_q.push_back(flag);
        nfaer_seq_inst.issue(num, word, w0, w1, ext);
        repeat (2) @(posedge ref_clk);
    endtask
    // Read data is judged at the rising edge where the bus master takes it; the error flag at the edge where instr_done is high.
    always @(posedge ref_clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            chk("readdata", avs_readdata, rd_q.pop_front());
        end
        if (instr_done === 1'b1) begin
            chk("error_flag", instr_error_flag, flag_q.pop_front());
        end
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles > 3000) begin
            bad_count++;
            end_sim();
        end
    end
    initial begin
        {avs_read, avs_write, avs_address, avs_writedata} = '0;
        avs_byteenable = 4'hF;
        rst = 1'b1;
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        bus(IDX_STATUS, 0, 16'h0000);
        ins(16'h0005, 0, 16'h1234, 0, 0, 0);
        bus(IDX_CODE, 1, 16'h1111);
        bus(IDX_CODE, 0, 16'h4105);
        bus(IDX_STATUS, 0, 16'h8000);
        bus(IDX_BITMAP_BASE, 0, 16'h0020);
        ins(16'h01FF, 0, 16'hFFFF, 0, 0, 0);
        bus(IDX_BITMAP_LAST, 0, 16'h8000);
        ins(16'h0200, 0, 0, 0, 0, 1);
        ins({1'b1, 15'($random(seed))}, 0, 0, 0, 0, 1);
        ins(16'h0003, 1, 0, 0, 0, 0);
        chk("msg_text", msg_text, nfaer_seq_inst.sent_msg);
        chk("msg_owner", {msg_valid, msg_alarm_num}, {1'b1, 9'h003});
        bus(IDX_CODE, 0, 16'h4103);
        ins(0, 0, 16'h0003, 0, 0, 0);
        bus(IDX_BITMAP_BASE, 0, 16'h0020);
        bus(IDX_CODE, 0, 16'h4105);
        ins(0, 0, 16'h0200, 0, 0, 0);
        bus(IDX_CODE, 0, 16'h42FF);
        ins(0, 1, 0, 0, 0, 0);
        bus(IDX_STATUS, 0, 16'h0000);
        bus(IDX_DUMMY, 1, 16'h0007);
        bus(IDX_DUMMY, 0, 16'h0007);
        ins(16'h0007, 0, SYS_CODE_OPTION, 16'h0002, 0, 1);
        ins(16'h0007, 0, 16'h0042, 0, 0, 1);
        for (int i = 3; i >= 0; i--) ins(16'h0007, 0, codes[i], dets[i], 0, 0);
        bus(IDX_CODE, 0, SYS_CODE_SETUP);
        bus(IDX_BITMAP_BASE, 0, 16'h0000);
        // A later alarm writes its own code even while a system error stands.
        ins(16'h0002, 1, 0, 0, 0, 0);
        bus(IDX_CODE, 0, 16'h4102);
        ins(0, 0, 16'hFFFF, 0, 0, 0);
        bus(IDX_CODE, 0, 16'h0000);
        chk("msg_valid", msg_valid, 1'b0);
        for (int i = 0; i < 16; i++) begin
            n = 16'h0008 + (16'($random(seed)) & 16'h01F7);
            ins(n, 0, 0, 0, 0, 0);
        end
        bus(IDX_LOG_STATE, 0, 16'h0414);
        bus(IDX_LOG_BASE + 10'd15, 0, 16'h4100 + n);
        bus(IDX_LOG_BASE + 10'd16, 0, nfaer_seq_inst.sent_time[15:0]);
        bus(IDX_LOG_LAST + 10'd1, 0, 16'h0000);
        bus(IDX_CONFIG, 1, 16'h0001);
        ins(16'h0009, 0, 0, 0, 0, 0);
        bus(IDX_LOG_STATE, 0, 16'h0414);
        bus(IDX_STATUS, 0, 16'h8000);
        bus(IDX_CODE, 0, 16'h4109);
        ins(16'h0004, 0, 0, 0, 1, 0);
        bus(IDX_CODE, 0, 16'h80F1);
        // A later non-fatal alarm must not displace the held fatal code.
        ins(16'h0006, 0, 0, 0, 0, 0);
        bus(IDX_CODE, 0, 16'h80F1);
        chk("pending", 128'(rd_q.size() + flag_q.size()), 128'h0);
        end_sim();
    end
endmodule
bind nfaer_core nfaer_core_checker nfaer_core_checker_inst (.ref_clk, .rst, .instr_req,
    .alarm_num, .src_is_word, .src_word0, .msg_words, .instr_done, .instr_error_flag,
    .halt_req, .msg_text, .msg_valid, .msg_alarm_num);
